// ===== sfr_pkg.sv
// Constants shared by the status flag register block.
package sfr_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [6:0] STATUS_ADDR = 7'h01;
   localparam int STATUS_WIDTH = 24;
   localparam logic [23:0] STATUS_RESET = 24'h00_0000;

   // ----------------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------------
   localparam int FAST_RECOVERY_BIT = 21;
   localparam int DC_LEAD_OFF_BIT = 20;
   localparam int LEADS_ON_BIT = 11;
   localparam int R_EVENT_BIT = 10;
   localparam int SAMPLE_SYNC_BIT = 9;
   localparam int PLL_UNLOCK_BIT = 8;
   localparam int DETAIL_LSB = 0;
   localparam int DETAIL_MSB = 3;

   // ----------------------------------------------------------------------
   // Serial frame layout
   // ----------------------------------------------------------------------
   localparam logic [5:0] ADDR_LAST_EDGE = 6'h07;
   localparam logic [5:0] DATA_FIRST_CNT = 6'h08;
   localparam logic [5:0] FRAME_LAST_CNT = 6'h1F;
   localparam logic [5:0] FRAME_DONE_CNT = 6'h20;

   // ----------------------------------------------------------------------
   // Field codes
   // ----------------------------------------------------------------------
   localparam logic [1:0] LON_MODE_A = 2'h1;
   localparam logic [1:0] LON_MODE_B = 2'h2;
   localparam logic [1:0] RCLR_ON_STATUS = 2'h0;
   localparam logic [1:0] RCLR_ON_INTERVAL = 2'h1;
   localparam logic [1:0] RCLR_SELF = 2'h2;
   localparam logic SCLR_ON_STATUS = 1'b0;
   localparam logic SCLR_SELF = 1'b1;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 100_000;
   localparam int LEAD_OFF_TIME_MS = 115;
   localparam int LEAD_OFF_CYCLES = LEAD_OFF_TIME_MS * CLK_FREQ_KHZ;
   localparam logic [2:0] R_SELF_QUARTERS = 3'h4;
   localparam logic [2:0] SAMPLE_SYNC_FLAG_SELF_QUARTERS = 3'h1;

endpackage : sfr_pkg

// ===== sfr_status_flags.sv
// Status flag register with its serial read port.
//
// Operation
// R1: Fast-recovery flag sets on fast mode engagement.
// R2: DC lead-off flag needs over 115ms persistence.
// R3: DC lead-off holds while present, then until read.
// R4: Leads-on flag sets on entering leads-on mode.
// R5: Host reads status once to arm leads-on.
// R6: Leads-on flag holds while present, then until read.
// R7: R-event flag sets on each new R event.
// R8: Sample flag issued on base-rate instant, interval-divided.
// R9: Host should route sample flag to dedicated interrupt.
// R10: PLL flag sets while PLL is unlocked.
// R11: PLL flag never set with channel disabled.
// R12: PLL flag holds while unlocked, then until read.
// R13: Detail bits report four input threshold conditions.
// R14: Detail bits hold while present, then until read.
// R15: Detail bits assert together with DC lead-off flag.
// R16: All flags active high, independent of enables; PLL flag gated by i_channel_enable, DC lead-off by i_dc_lead_off_enable.
// R17: Fast clear mode picks level or entry-edge behaviour.
// R18: R-event clear mode picks status, interval or self.
// R19: Sample clear bit picks status read or self.
// R20: Unused bits read zero; writes are ignored.
`timescale 1ns/10ps
module sfr_status_flags
   import sfr_pkg::*;
#(
   parameter int P_LEAD_OFF_CYCLES = LEAD_OFF_CYCLES
)
(
   // System clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Serial port
   input wire logic i_sclk,
   input wire logic i_csb_n,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe,
   // Configuration fields
   input wire logic i_fast_flag_clear_mode,
   input wire logic [1:0] i_r_event_clear_mode,
   input wire logic i_sample_flag_clear_mode,
   input wire logic [1:0] i_sample_pulse_interval,
   input wire logic [1:0] i_low_power_leads_on_enable,
   input wire logic i_channel_enable,
   input wire logic i_dc_lead_off_enable,
   // Raw conditions and events
   input wire logic i_fast_mode_active,
   input wire logic i_dc_lead_off,
   input wire logic [3:0] i_lead_off_detail,
   input wire logic i_leads_on,
   input wire logic i_r_event,
   input wire logic i_base_rate_instant,
   input wire logic i_quarter_rate_tick,
   input wire logic i_pll_locked,
   input wire logic i_interval_read,
   // Status view
   output logic [23:0] o_event_status
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [5:0] edge_cnt_q;
   logic [6:0] addr_sh_q;
   logic read_sel_q;
   logic clr_tgl_q;
   logic [23:0] snap_q;
   logic csb_meta_q;
   logic csb_sync_q;
   logic tgl_meta_q;
   logic tgl_sync_q;
   logic tgl_seen_q;
   logic read_done;
   logic [23:0] clr_mask;
   logic fast_prev_q;
   logic fast_flag_q;
   logic fast_set;
   logic [23:0] lo_cnt_q;
   logic lo_raw;
   logic lo_qual;
   logic dc_flag_q;
   logic [3:0] detail_q;
   logic lon_mode;
   logic lon_mode_q;
   logic lon_entry;
   logic lon_armed_q;
   logic lon_flag_q;
   logic r_flag_q;
   logic [2:0] r_age_q;
   logic r_clear;
   logic [1:0] sample_sync_flag_div_q;
   logic sample_sync_flag_pulse;
   logic sample_sync_flag_flag_q;
   logic [2:0] sample_sync_flag_age_q;
   logic sample_sync_flag_clear;
   logic pll_flag_q;
   logic [23:0] status_word;

   // Counter of quarter data-rate ticks seen since a flag was set.
   function automatic logic [2:0] age_next(input logic set, input logic flag,
                                           input logic tick, input logic [2:0] age,
                                           input logic [2:0] limit);
      logic [2:0] nxt;
      nxt = age;
      if (set)
      begin
         nxt = 3'h0;
      end
      else if (flag && tick && (age != limit))
      begin
         nxt = age + 3'h1;
      end
      return nxt;
   endfunction : age_next

   // ----------------------------------------------------------------------
   // Serial link domain
   // ----------------------------------------------------------------------
   // Frame bit counter and address capture; chip select high ends the frame.
   always_ff @(posedge i_sclk or posedge i_csb_n)
   begin
      if (i_csb_n)
      begin
         edge_cnt_q <= 6'h00;
         addr_sh_q <= 7'h00;
         read_sel_q <= 1'b0;
      end
      else
      begin
         if (edge_cnt_q != FRAME_DONE_CNT)
         begin
            edge_cnt_q <= edge_cnt_q + 6'h01;
         end
         if (edge_cnt_q < ADDR_LAST_EDGE)
         begin
            addr_sh_q <= {addr_sh_q[5:0], i_sdi};
         end
         // R20: writes ignored
         if (edge_cnt_q == ADDR_LAST_EDGE)
         begin
            read_sel_q <= (addr_sh_q == STATUS_ADDR) && i_sdi;
         end
      end
   end

   // Read data leaves on falling edges, most significant bit first.
   always_ff @(negedge i_sclk or posedge i_csb_n)
   begin
      if (i_csb_n)
      begin
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
      end
      else if (read_sel_q && (edge_cnt_q >= DATA_FIRST_CNT) &&
               (edge_cnt_q <= FRAME_LAST_CNT))
      begin
         o_sdo <= snap_q[5'(FRAME_LAST_CNT - edge_cnt_q)];
         o_sdo_oe <= 1'b1;
      end
      else
      begin
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
      end
   end

   // R3: clear on 32nd edge
   always_ff @(posedge i_sclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         clr_tgl_q <= 1'b0;
      end
      else if (!i_csb_n && read_sel_q && (edge_cnt_q == FRAME_LAST_CNT))
      begin
         clr_tgl_q <= ~clr_tgl_q;
      end
   end

   // ----------------------------------------------------------------------
   // Crossings into the system domain
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         csb_meta_q <= 1'b1;
         csb_sync_q <= 1'b1;
         tgl_meta_q <= 1'b0;
         tgl_sync_q <= 1'b0;
         tgl_seen_q <= 1'b0;
      end
      else
      begin
         csb_meta_q <= i_csb_n;
         csb_sync_q <= csb_meta_q;
         tgl_meta_q <= clr_tgl_q;
         tgl_sync_q <= tgl_meta_q;
         tgl_seen_q <= tgl_sync_q;
      end
   end

   assign read_done = tgl_sync_q ^ tgl_seen_q;
   // Only bits that the host actually saw as set are cleared by the read.
   assign clr_mask = read_done ? snap_q : STATUS_RESET;

   // The snapshot freezes while a frame is open, so the link reads a stable word.
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         snap_q <= STATUS_RESET;
      end
      else if (csb_sync_q)
      begin
         snap_q <= status_word;
      end
   end

   // ----------------------------------------------------------------------
   // Fast recovery flag
   // ----------------------------------------------------------------------
   // R17: level or entry edge
   assign fast_set = i_fast_flag_clear_mode ? (i_fast_mode_active && !fast_prev_q)
                                            : i_fast_mode_active;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         fast_prev_q <= 1'b0;
         fast_flag_q <= 1'b0;
      end
      else
      begin
         fast_prev_q <= i_fast_mode_active;
         // R1: set on engagement
         fast_flag_q <= fast_set || (fast_flag_q && !clr_mask[FAST_RECOVERY_BIT]);
      end
   end

   // ----------------------------------------------------------------------
   // DC lead-off flag and detail bits
   // ----------------------------------------------------------------------
   assign lo_raw = i_dc_lead_off_enable && i_dc_lead_off;
   assign lo_qual = lo_raw && (lo_cnt_q == P_LEAD_OFF_CYCLES[23:0]);

   // R2: persistence timer
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         lo_cnt_q <= 24'h00_0000;
      end
      else if (!lo_raw)
      begin
         lo_cnt_q <= 24'h00_0000;
      end
      else if (lo_cnt_q != P_LEAD_OFF_CYCLES[23:0])
      begin
         lo_cnt_q <= lo_cnt_q + 24'h00_0001;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         dc_flag_q <= 1'b0;
         detail_q <= 4'h0;
      end
      else
      begin
         // R3: hold then latch
         dc_flag_q <= lo_qual || (dc_flag_q && !clr_mask[DC_LEAD_OFF_BIT]);
         // R15: same cycle as flag
         // R14: detail hold then latch
         // R13: four detail conditions
         detail_q <= (lo_qual ? i_lead_off_detail : 4'h0) |
                     (detail_q & ~clr_mask[DETAIL_MSB:DETAIL_LSB]);
      end
   end

   // ----------------------------------------------------------------------
   // Leads-on flag
   // ----------------------------------------------------------------------
   assign lon_mode = (i_low_power_leads_on_enable == LON_MODE_A) ||
                     (i_low_power_leads_on_enable == LON_MODE_B);
   assign lon_entry = lon_mode && !lon_mode_q;

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         lon_mode_q <= 1'b0;
         lon_armed_q <= 1'b0;
         lon_flag_q <= 1'b0;
      end
      else
      begin
         lon_mode_q <= lon_mode;
         // R5: first read arms detection
         if (!lon_mode || lon_entry)
         begin
            lon_armed_q <= 1'b0;
         end
         else if (clr_mask[LEADS_ON_BIT])
         begin
            lon_armed_q <= 1'b1;
         end
         // R4: set on mode entry
         // R6: hold then latch
         lon_flag_q <= lon_entry || (lon_armed_q && lon_mode && i_leads_on) ||
                       (lon_flag_q && !clr_mask[LEADS_ON_BIT]);
      end
   end

   // ----------------------------------------------------------------------
   // R-event flag
   // ----------------------------------------------------------------------
   // R18: clear source select
   always_comb
   begin
      if (i_r_event_clear_mode == RCLR_ON_INTERVAL)
      begin
         r_clear = i_interval_read;
      end
      else if (i_r_event_clear_mode == RCLR_SELF)
      begin
         r_clear = (r_age_q == R_SELF_QUARTERS);
      end
      else
      begin
         r_clear = clr_mask[R_EVENT_BIT];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         r_flag_q <= 1'b0;
         r_age_q <= 3'h0;
      end
      else
      begin
         // R7: set per R event
         r_flag_q <= i_r_event || (r_flag_q && !r_clear);
         r_age_q <= age_next(i_r_event, r_flag_q, i_quarter_rate_tick, r_age_q,
                             R_SELF_QUARTERS);
      end
   end

   // ----------------------------------------------------------------------
   // Sample synchronisation flag
   // ----------------------------------------------------------------------
   assign sample_sync_flag_pulse = i_base_rate_instant && (sample_sync_flag_div_q == 2'h0);

   // R19: clear source select
   assign sample_sync_flag_clear = (i_sample_flag_clear_mode == SCLR_SELF) ?
                       (sample_sync_flag_age_q == SAMPLE_SYNC_FLAG_SELF_QUARTERS) : clr_mask[SAMPLE_SYNC_BIT];

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         sample_sync_flag_div_q <= 2'h0;
         sample_sync_flag_flag_q <= 1'b0;
         sample_sync_flag_age_q <= 3'h0;
      end
      else
      begin
         // R8: interval divides instants
         if (i_base_rate_instant)
         begin
            sample_sync_flag_div_q <= (sample_sync_flag_div_q >= i_sample_pulse_interval) ? 2'h0
                                                                 : sample_sync_flag_div_q + 2'h1;
         end
         sample_sync_flag_flag_q <= sample_sync_flag_pulse || (sample_sync_flag_flag_q && !sample_sync_flag_clear);
         sample_sync_flag_age_q <= age_next(sample_sync_flag_pulse, sample_sync_flag_flag_q, i_quarter_rate_tick,
                                sample_sync_flag_age_q, SAMPLE_SYNC_FLAG_SELF_QUARTERS);
      end
   end

   // ----------------------------------------------------------------------
   // PLL unlock flag
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pll_flag_q <= 1'b0;
      end
      else
      begin
         // R11: only with channel on
         // R10: set while unlocked
         // R12: hold then latch
         pll_flag_q <= i_channel_enable &&
                       (!i_pll_locked || (pll_flag_q && !clr_mask[PLL_UNLOCK_BIT]));
      end
   end

   // ----------------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------------
   // R16: active high flags
   // R20: unused bits zero
   always_comb
   begin
      status_word = STATUS_RESET;
      status_word[FAST_RECOVERY_BIT] = fast_flag_q;
      status_word[DC_LEAD_OFF_BIT] = dc_flag_q;
      status_word[LEADS_ON_BIT] = lon_flag_q;
      status_word[R_EVENT_BIT] = r_flag_q;
      status_word[SAMPLE_SYNC_BIT] = sample_sync_flag_flag_q;
      status_word[PLL_UNLOCK_BIT] = pll_flag_q;
      status_word[DETAIL_MSB:DETAIL_LSB] = detail_q;
   end

   assign o_event_status = status_word;

endmodule : sfr_status_flags

// ===== sfr_status_flags_asserts.sv
// Port-level checks for the status flag register.
`timescale 1ns/10ps
module sfr_status_flags_asserts
   import sfr_pkg::*;
#(
   parameter int P_LEAD_OFF_CYCLES = LEAD_OFF_CYCLES
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Watched inputs
   input wire logic i_fast_mode_active,
   input wire logic [1:0] i_r_event_clear_mode,
   input wire logic i_sample_flag_clear_mode,
   input wire logic [1:0] i_sample_pulse_interval,
   input wire logic [1:0] i_low_power_leads_on_enable,
   input wire logic i_channel_enable,
   input wire logic i_dc_lead_off_enable,
   input wire logic i_dc_lead_off,
   input wire logic i_r_event,
   input wire logic i_base_rate_instant,
   input wire logic i_quarter_rate_tick,
   input wire logic i_pll_locked,
   input wire logic i_interval_read,
   // Watched outputs
   input wire logic [23:0] o_event_status
);
   logic [31:0] lo_cnt_q;
   logic lo_now;
   logic lon_now;
   assign lo_now = i_dc_lead_off && i_dc_lead_off_enable;
   assign lon_now = (i_low_power_leads_on_enable == LON_MODE_A) ||
                    (i_low_power_leads_on_enable == LON_MODE_B);
   // Counts consecutive cycles of an enabled lead-off condition.
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         lo_cnt_q <= 32'h0000_0000;
      else
         lo_cnt_q <= lo_now ? lo_cnt_q + 32'h0000_0001 : 32'h0000_0000;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   AST_FAST_SET: assert property ($rose(i_fast_mode_active) |=> o_event_status[21])
      else $error("fast flag missed");
   AST_DC_LATE: assert property ($rose(o_event_status[20]) |-> lo_cnt_q > P_LEAD_OFF_CYCLES)
      else $error("lead-off flag early");
   AST_DC_DUE: assert property (lo_cnt_q == P_LEAD_OFF_CYCLES + 3 |-> o_event_status[20])
      else $error("lead-off flag late");
   AST_DC_HOLD: assert property (o_event_status[20] && lo_now |=> o_event_status[20])
      else $error("lead-off flag dropped");
   AST_LON_ENTRY: assert property (lon_now && !$past(lon_now) |=> o_event_status[11])
      else $error("leads-on entry flag missed");
   AST_R_SET: assert property (i_r_event |=> o_event_status[10])
      else $error("r event flag missed");
   AST_SAMPLE_SYNC_FLAG_SET: assert property (i_base_rate_instant && i_sample_pulse_interval == 2'h0
      |=> o_event_status[9]) else $error("sample flag missed");
   AST_PLL_SET: assert property (!i_pll_locked && i_channel_enable |=> o_event_status[8])
      else $error("pll flag missed");
   AST_PLL_OFF: assert property (!i_channel_enable && !$past(i_channel_enable)
      |-> !o_event_status[8]) else $error("pll flag while disabled");
   AST_DETAIL_WITH_DC: assert property (o_event_status[3:0] != 4'h0 |-> o_event_status[20])
      else $error("detail bits without lead-off flag");
   AST_RESERVED_ZERO: assert property ((o_event_status & 24'hCF_F0F0) == 24'h00_0000)
      else $error("unused status bit set");
   AST_R_INTERVAL_CLR: assert property (o_event_status[10] && i_interval_read && !i_r_event
      && i_r_event_clear_mode == RCLR_ON_INTERVAL |=> !o_event_status[10])
      else $error("r event flag not cleared");
   AST_SAMPLE_SYNC_FLAG_SELF_CLR: assert property (o_event_status[9] && i_sample_flag_clear_mode
      && i_quarter_rate_tick && !i_base_rate_instant |-> ##[1:2] !o_event_status[9])
      else $error("sample flag not self cleared");
   COV_DC: cover property ($rose(o_event_status[20]));
   COV_LON: cover property ($rose(o_event_status[11]));
   COV_PLL: cover property ($rose(o_event_status[8]));
endmodule : sfr_status_flags_asserts

bind sfr_status_flags sfr_status_flags_asserts #(.P_LEAD_OFF_CYCLES(P_LEAD_OFF_CYCLES)) i_chk (
   .i_clk_sys, .i_sys_rst, .i_fast_mode_active, .i_r_event_clear_mode,
   .i_sample_flag_clear_mode, .i_sample_pulse_interval, .i_low_power_leads_on_enable,
   .i_channel_enable, .i_dc_lead_off_enable, .i_dc_lead_off, .i_r_event,
   .i_base_rate_instant, .i_quarter_rate_tick, .i_pll_locked, .i_interval_read,
   .o_event_status
);

// ===== sfr_host_model.sv
// Host controller model that runs serial frames.
`timescale 1ns/10ps
module sfr_host_model
   import sfr_pkg::*;
(
   // Serial port
   output logic o_sclk,
   output logic o_csb_n,
   output logic o_sdi,
   input wire logic i_sdo
);
   initial
   begin
      o_sclk = 1'h0;
      o_csb_n = 1'h1;
      o_sdi = 1'h0;
   end
   // One frame of n edges; the link clock only runs inside the frame.
   task automatic frame(input logic [6:0] addr, input logic rw, input int n,
                        output logic [23:0] data);
      logic [7:0] cmd;
      cmd = {addr, rw};
      data = 24'h00_0000;
      o_csb_n = 1'h0;
      #45;
      for (int i = 0; i < n; i++)
      begin
         o_sdi = (i < 8) ? cmd[7 - i] : ~o_sdi;
         #7.5 o_sclk = 1'h1;
         if (i >= 8)
            data = {data[22:0], i_sdo};
         #7.5 o_sclk = 1'h0;
      end
      #45 o_csb_n = 1'h1;
      o_sdi = ~o_sdi;
      #45;
   endtask : frame
endmodule : sfr_host_model

// ===== sfr_status_flags_tb.sv
// Self-checking bench for the status flag register.
`timescale 1ns/10ps
module sfr_status_flags_tb
   import sfr_pkg::*;
;
   logic i_clk_sys, i_sys_rst, i_sclk, i_csb_n, i_sdi, o_sdo, o_sdo_oe;
   logic i_fast_flag_clear_mode, i_sample_flag_clear_mode, i_channel_enable;
   logic i_dc_lead_off_enable, i_fast_mode_active, i_dc_lead_off, i_leads_on;
   logic i_r_event, i_base_rate_instant, i_quarter_rate_tick, i_pll_locked, i_interval_read;
   logic [1:0] i_r_event_clear_mode, i_sample_pulse_interval, i_low_power_leads_on_enable;
   logic [3:0] i_lead_off_detail;
   logic [23:0] o_event_status, rd;
   int failures = 0;
   int n_checks = 0;
   // Stimulus bits: pll unlock, fast mode, base instant, r event. Clear: 0 read, 1/2 pulses.
   typedef struct packed {
      logic [3:0] stim;
      logic [1:0] rcm;
      logic scm, fcm, hold;
      logic [1:0] act;
      logic [23:0] exp, after;
   } sfr_row_s;
   sfr_row_s rows [11] = '{
      '{4'h1, 2'h0, 1'h0, 1'h0, 1'h0, 2'h0, 24'h00_0400, 24'h00_0000},
      '{4'h1, 2'h1, 1'h0, 1'h0, 1'h0, 2'h0, 24'h00_0400, 24'h00_0400},
      '{4'h1, 2'h1, 1'h0, 1'h0, 1'h0, 2'h1, 24'h00_0400, 24'h00_0000},
      '{4'h1, 2'h2, 1'h0, 1'h0, 1'h0, 2'h2, 24'h00_0400, 24'h00_0000},
      '{4'h1, 2'h3, 1'h0, 1'h0, 1'h0, 2'h0, 24'h00_0400, 24'h00_0000},
      '{4'h2, 2'h0, 1'h0, 1'h0, 1'h0, 2'h0, 24'h00_0200, 24'h00_0000},
      '{4'h2, 2'h0, 1'h1, 1'h0, 1'h0, 2'h2, 24'h00_0200, 24'h00_0000},
      '{4'h4, 2'h0, 1'h0, 1'h0, 1'h1, 2'h0, 24'h20_0000, 24'h20_0000},
      '{4'h4, 2'h0, 1'h0, 1'h1, 1'h1, 2'h0, 24'h20_0000, 24'h00_0000},
      '{4'h8, 2'h0, 1'h0, 1'h0, 1'h1, 2'h0, 24'h00_0100, 24'h00_0100},
      '{4'h8, 2'h0, 1'h0, 1'h0, 1'h0, 2'h0, 24'h00_0100, 24'h00_0000}
   };

   sfr_status_flags #(.P_LEAD_OFF_CYCLES(20)) i_dut (
      .i_clk_sys, .i_sys_rst, .i_sclk, .i_csb_n, .i_sdi, .o_sdo, .o_sdo_oe,
      .i_fast_flag_clear_mode, .i_r_event_clear_mode, .i_sample_flag_clear_mode,
      .i_sample_pulse_interval, .i_low_power_leads_on_enable, .i_channel_enable,
      .i_dc_lead_off_enable, .i_fast_mode_active, .i_dc_lead_off, .i_lead_off_detail,
      .i_leads_on, .i_r_event, .i_base_rate_instant, .i_quarter_rate_tick, .i_pll_locked,
      .i_interval_read, .o_event_status
   );
   sfr_host_model i_host (.o_sclk(i_sclk), .o_csb_n(i_csb_n), .o_sdi(i_sdi), .i_sdo(o_sdo));

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : cyc

   task automatic look(input int n, input logic [23:0] exp);
      cyc(n);
      @(negedge i_clk_sys);
      chk(o_event_status, exp);
   endtask : look

   task automatic rd_chk(input logic [23:0] exp);
      i_host.frame(STATUS_ADDR, 1'h1, 32, rd);
      chk(rd, exp);
      cyc(8);
   endtask : rd_chk

   task automatic oe_chk(input logic rw, input logic exp);
      fork
         i_host.frame(STATUS_ADDR, rw, 32, rd);
         #310 chk({23'h00_0000, o_sdo_oe}, {23'h00_0000, exp});
      join
   endtask : oe_chk

   task automatic pulse(input logic [1:0] act);
      repeat ((act == 2'h1) ? 1 : 4)
      begin
         cyc(1);
         i_interval_read <= (act == 2'h1);
         i_quarter_rate_tick <= (act == 2'h2);
         cyc(1);
         {i_interval_read, i_quarter_rate_tick} <= 2'h0;
      end
   endtask : pulse

   task automatic report_and_stop;
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   initial
   begin
      i_clk_sys = 1'h0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   initial
   begin
      #300_000;
      failures++;
      report_and_stop();
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      {i_fast_flag_clear_mode, i_sample_flag_clear_mode, i_fast_mode_active, i_dc_lead_off,
       i_leads_on, i_r_event, i_base_rate_instant, i_quarter_rate_tick, i_interval_read} = 9'h000;
      {i_channel_enable, i_dc_lead_off_enable, i_pll_locked, i_sys_rst} = 4'hF;
      {i_r_event_clear_mode, i_sample_pulse_interval, i_low_power_leads_on_enable} = 6'h00;
      i_lead_off_detail = 4'h0;
      cyc(6);
      i_sys_rst <= 1'h0;
      rd_chk(STATUS_RESET);
      oe_chk(1'h1, 1'h1);
      foreach (rows[k])
      begin
         cyc(1);
         i_r_event_clear_mode <= rows[k].rcm;
         i_sample_flag_clear_mode <= rows[k].scm;
         i_fast_flag_clear_mode <= rows[k].fcm;
         cyc(1);
         {i_pll_locked, i_fast_mode_active, i_base_rate_instant, i_r_event} <= rows[k].stim ^ 4'h8;
         cyc(1);
         {i_base_rate_instant, i_r_event} <= 2'h0;
         if (!rows[k].hold)
            {i_pll_locked, i_fast_mode_active} <= 2'h2;
         look(2, rows[k].exp);
         if (rows[k].act == 2'h0)
            rd_chk(rows[k].exp);
         else
            pulse(rows[k].act);
         look(2, rows[k].after);
         cyc(1);
         {i_pll_locked, i_fast_mode_active} <= 2'h2;
         rd_chk(rows[k].after);
      end
      cyc(1);
      {i_channel_enable, i_pll_locked} <= 2'h0;
      look(4, 24'h00_0000);
      cyc(1);
      {i_channel_enable, i_pll_locked} <= 2'h3;
      i_lead_off_detail <= 4'hA;
      i_dc_lead_off <= 1'h1;
      look(15, 24'h00_0000);
      look(15, 24'h10_000A);
      cyc(1);
      {i_dc_lead_off, i_lead_off_detail} <= 5'h00;
      look(4, 24'h10_000A);
      rd_chk(24'h10_000A);
      look(1, 24'h00_0000);
      for (int c = 1; c < 3; c++)
      begin
         cyc(1);
         i_low_power_leads_on_enable <= c[1:0];
         look(3, 24'h00_0800);
         rd_chk(24'h00_0800);
         look(1, 24'h00_0000);
         cyc(1);
         i_leads_on <= 1'h1;
         look(3, 24'h00_0800);
         cyc(1);
         i_leads_on <= 1'h0;
         look(3, 24'h00_0800);
         rd_chk(24'h00_0800);
         cyc(1);
         i_low_power_leads_on_enable <= 2'h0;
      end
      cyc(1);
      {i_sample_pulse_interval, i_base_rate_instant} <= 3'h3;
      cyc(1);
      i_base_rate_instant <= 1'h0;
      rd_chk(24'h00_0200);
      cyc(1);
      i_base_rate_instant <= 1'h1;
      cyc(1);
      i_base_rate_instant <= 1'h0;
      look(2, 24'h00_0000);
      cyc(1);
      i_r_event <= 1'h1;
      cyc(1);
      i_r_event <= 1'h0;
      cyc(3);
      oe_chk(1'h0, 1'h0);
      i_host.frame(7'h02, 1'h1, 32, rd);
      chk(rd, 24'h00_0000);
      i_host.frame(STATUS_ADDR, 1'h1, 20, rd);
      look(8, 24'h00_0400);
      cyc(1);
      i_sys_rst <= 1'h1;
      look(3, STATUS_RESET);
      cyc(3);
      i_sys_rst <= 1'h0;
      rd_chk(STATUS_RESET);
      report_and_stop();
   end
endmodule : sfr_status_flags_tb
